// ### src/pll_clock_pkg.sv
// constants shared by the clock generator control logic
package pll_clock_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_BANDWIDTH = 2'h1;
    localparam logic [1:0] ADDR_PROGRAMMING = 2'h2;

    // pll_control fields
    localparam int CTL_IRQ_EN_BIT = 7;
    localparam int CTL_FLAG_BIT = 6;
    localparam int CTL_LOOP_EN_BIT = 5;
    localparam int CTL_SEL_BIT = 4;
    localparam logic [3:0] CTL_UNUSED_VAL = 4'hf;

    // pll_bandwidth_control fields
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_ACQ_BIT = 5;
    localparam int BW_XLD_BIT = 4;
    localparam logic [3:0] BW_TEST_VAL = 4'h0;

    // pll_programming fields
    localparam int PRG_MUL_LSB = 4;
    localparam int PRG_VRS_LSB = 0;

    // reset values
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_LOOP_EN = 1'b1;
    localparam logic RST_SEL = 1'b0;
    localparam logic RST_AUTO = 1'b0;
    localparam logic RST_ACQ = 1'b0;
    localparam logic [3:0] RST_MUL = 4'h6;
    localparam logic [3:0] RST_VRS = 4'h6;

    // source switch waits this many edges of each source clock
    localparam logic [1:0] SWITCH_EDGES = 2'h3;

    typedef enum logic [1:0] {
        SRC_RUN = 2'b01,
        SRC_SWITCH = 2'b10
    } src_state_e;
endpackage

// ### src/pll_clock_gen_control.sv
// register and base clock control of the pll clock generator
//
// What this block does
// - irq enable frozen, reads zero in manual mode
// - lock toggle sets flag; flag and enable raise irq
// - flag reads zero in manual mode
// - a control register read clears the flag, unless a lock toggle sets it that cycle
// - loop enable cannot clear while vco selected
// - select cannot set while loop is off
// - source switch waits three edges each (crystal only while loop off), output held
// - reset and stop clear the select bit
// - base clock is selected source halved, 50% duty
// - low control bits read as ones
// - auto bandwidth bit read/write, reset clears
// - lock bit live in auto, zero in manual
// - tracking bit status in auto, control in manual
// - manual tracking value kept across auto mode
// - crystal loss bit reads one when armed by a write and crystal idle
// - crystal loss reads zero unless vco selected
// - multiplier zero means one, reset six
// - multiplier unwritable while loop enabled
// - range unwritable while loop enabled, reset six
// - zero range disables loop and forces crystal
// - multiplier upper nibble, range lower nibble
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pll_clock_gen_control (
    input wire logic clock_i, // 250 mhz system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic [1:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic crystal_clk_i, // crystal oscillator clock
    input wire logic vco_clk_i, // vco clock
    input wire logic lock_det_i, // analog lock detector
    input wire logic track_det_i, // analog tracking detector
    input wire logic osc_enable_in_i, // oscillator enable
    input wire logic stop_i, // stop instruction executing
    output logic base_clk_out_o, // base clock
    output logic lock_irq_o, // cpu interrupt request
    output logic loop_on_o, // loop running
    output logic filter_track_o, // filter in tracking mode
    output logic [3:0] feedback_div_o, // feedback divider n
    output logic [3:0] vco_range_o // vco range l
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] eff_mult(input logic [3:0] m);
        eff_mult = (m == 4'h0) ? 4'h1 : m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronisers; the first stage feeds only the second
    logic x_s1_r, x_s2_r, x_s3_r;
    logic v_s1_r, v_s2_r, v_s3_r;
    logic lk_s1_r, lk_s2_r, lk_s3_r;
    logic tk_s1_r, tk_s2_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            x_s1_r <= 1'b0;
            x_s2_r <= 1'b0;
            x_s3_r <= 1'b0;
            v_s1_r <= 1'b0;
            v_s2_r <= 1'b0;
            v_s3_r <= 1'b0;
            lk_s1_r <= 1'b0;
            lk_s2_r <= 1'b0;
            lk_s3_r <= 1'b0;
            tk_s1_r <= 1'b0;
            tk_s2_r <= 1'b0;
        end else begin
            x_s1_r <= crystal_clk_i;
            x_s2_r <= x_s1_r;
            x_s3_r <= x_s2_r;
            v_s1_r <= vco_clk_i;
            v_s2_r <= v_s1_r;
            v_s3_r <= v_s2_r;
            lk_s1_r <= lock_det_i;
            lk_s2_r <= lk_s1_r;
            lk_s3_r <= lk_s2_r;
            tk_s1_r <= track_det_i;
            tk_s2_r <= tk_s1_r;
        end
    end

    logic x_edge, v_edge;
    assign x_edge = x_s2_r & ~x_s3_r;
    assign v_edge = v_s2_r & ~v_s3_r;

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic irq_en_r, irq_en_nxt;
    logic flag_r, flag_nxt;
    logic loop_en_r, loop_en_nxt;
    logic sel_r, sel_nxt;
    logic auto_r, auto_nxt;
    logic acq_man_r, acq_man_nxt;
    logic xld_r, xld_nxt;
    logic [3:0] mul_r, mul_nxt;
    logic [3:0] vrs_r, vrs_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic loop_on_r, loop_on_nxt;
    logic track_r, track_nxt;
    logic [3:0] fb_div_r, fb_div_nxt;

    logic wr_ctl, wr_bw, wr_prg, rd_ctl, lock_toggle, vrs_zero;
    assign wr_ctl = wr_i && (addr_i == pll_clock_pkg::ADDR_CONTROL);
    assign wr_bw = wr_i && (addr_i == pll_clock_pkg::ADDR_BANDWIDTH);
    assign wr_prg = wr_i && (addr_i == pll_clock_pkg::ADDR_PROGRAMMING);
    assign rd_ctl = rd_i && (addr_i == pll_clock_pkg::ADDR_CONTROL);
    assign lock_toggle = auto_r && (lk_s2_r ^ lk_s3_r);
    assign vrs_zero = (vrs_r == 4'h0);

    always_comb begin
        irq_en_nxt = irq_en_r;
        flag_nxt = flag_r;
        loop_en_nxt = loop_en_r;
        sel_nxt = sel_r;
        auto_nxt = auto_r;
        acq_man_nxt = acq_man_r;
        xld_nxt = xld_r;
        mul_nxt = mul_r;
        vrs_nxt = vrs_r;
        rdata_nxt = 8'h00;
        if (wr_ctl) begin
            if (auto_r) begin
                irq_en_nxt = wdata_i[pll_clock_pkg::CTL_IRQ_EN_BIT];
            end
            // clearing the loop is refused while the vco drives the output
            loop_en_nxt = wdata_i[pll_clock_pkg::CTL_LOOP_EN_BIT] | sel_r;
            // old loop enable is used, so enabling and selecting take two writes
            sel_nxt = wdata_i[pll_clock_pkg::CTL_SEL_BIT] & loop_en_r;
        end
        if (stop_i || vrs_zero) begin
            sel_nxt = 1'b0;
        end
        if (rd_ctl) begin
            flag_nxt = 1'b0;
        end
        if (lock_toggle) begin
            flag_nxt = 1'b1; // set beats a same-cycle read clear
        end
        if (wr_bw) begin
            auto_nxt = wdata_i[pll_clock_pkg::BW_AUTO_BIT];
            if (!auto_r) begin
                acq_man_nxt = wdata_i[pll_clock_pkg::BW_ACQ_BIT];
            end
        end
        // any crystal edge seen while armed proves the reference alive
        if (!sel_r) begin
            xld_nxt = 1'b0;
        end else if (wr_bw && wdata_i[pll_clock_pkg::BW_XLD_BIT]) begin
            xld_nxt = 1'b1;
        end else if (x_edge) begin
            xld_nxt = 1'b0;
        end
        if (wr_prg && !loop_en_r) begin
            mul_nxt = wdata_i[pll_clock_pkg::PRG_MUL_LSB +: 4];
            vrs_nxt = wdata_i[pll_clock_pkg::PRG_VRS_LSB +: 4];
        end
        if (rd_i) begin
            case (addr_i)
                pll_clock_pkg::ADDR_CONTROL: begin
                    rdata_nxt = {irq_en_r & auto_r, flag_r & auto_r,
                                 loop_en_r, sel_r, pll_clock_pkg::CTL_UNUSED_VAL};
                end
                pll_clock_pkg::ADDR_BANDWIDTH: begin
                    rdata_nxt = {auto_r, lk_s2_r & auto_r,
                                 auto_r ? tk_s2_r : acq_man_r,
                                 xld_r & sel_r, pll_clock_pkg::BW_TEST_VAL};
                end
                pll_clock_pkg::ADDR_PROGRAMMING: begin
                    rdata_nxt = {mul_r, vrs_r};
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
        irq_nxt = flag_r && irq_en_r && auto_r && !stop_i;
        loop_on_nxt = loop_en_r && !vrs_zero && osc_enable_in_i && !stop_i;
        track_nxt = auto_r ? tk_s2_r : acq_man_r;
        fb_div_nxt = eff_mult(mul_r);
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_en_r <= pll_clock_pkg::RST_IRQ_EN;
            flag_r <= 1'b0;
            loop_en_r <= pll_clock_pkg::RST_LOOP_EN;
            sel_r <= pll_clock_pkg::RST_SEL;
            auto_r <= pll_clock_pkg::RST_AUTO;
            acq_man_r <= pll_clock_pkg::RST_ACQ;
            xld_r <= 1'b0;
            mul_r <= pll_clock_pkg::RST_MUL;
            vrs_r <= pll_clock_pkg::RST_VRS;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
            loop_on_r <= 1'b0;
            track_r <= 1'b0;
            fb_div_r <= pll_clock_pkg::RST_MUL;
        end else begin
            irq_en_r <= irq_en_nxt;
            flag_r <= flag_nxt;
            loop_en_r <= loop_en_nxt;
            sel_r <= sel_nxt;
            auto_r <= auto_nxt;
            acq_man_r <= acq_man_nxt;
            xld_r <= xld_nxt;
            mul_r <= mul_nxt;
            vrs_r <= vrs_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            loop_on_r <= loop_on_nxt;
            track_r <= track_nxt;
            fb_div_r <= fb_div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base clock: selected source halved, frozen during a source change
    pll_clock_pkg::src_state_e state_r, state_nxt;
    logic cur_src_r, cur_src_nxt;
    logic [1:0] xcnt_r, xcnt_nxt, vcnt_r, vcnt_nxt;
    logic base_r, base_nxt;
    logic src_edge, switch_done;
    assign src_edge = cur_src_r ? v_edge : x_edge;
    // a stopped vco cannot be waited for, so only the crystal count gates then
    assign switch_done = (xcnt_r == pll_clock_pkg::SWITCH_EDGES)
                         && ((vcnt_r == pll_clock_pkg::SWITCH_EDGES) || !loop_on_r);

    always_comb begin
        state_nxt = state_r;
        cur_src_nxt = cur_src_r;
        xcnt_nxt = xcnt_r;
        vcnt_nxt = vcnt_r;
        base_nxt = base_r;
        case (state_r)
            pll_clock_pkg::SRC_RUN: begin
                if (sel_r != cur_src_r) begin
                    state_nxt = pll_clock_pkg::SRC_SWITCH;
                    xcnt_nxt = 2'h0;
                    vcnt_nxt = 2'h0;
                end else if (src_edge && osc_enable_in_i) begin
                    base_nxt = ~base_r;
                end
            end
            pll_clock_pkg::SRC_SWITCH: begin
                if (x_edge && xcnt_r != pll_clock_pkg::SWITCH_EDGES) begin
                    xcnt_nxt = xcnt_r + 2'h1;
                end
                if (v_edge && vcnt_r != pll_clock_pkg::SWITCH_EDGES) begin
                    vcnt_nxt = vcnt_r + 2'h1;
                end
                if (switch_done) begin
                    state_nxt = pll_clock_pkg::SRC_RUN;
                    cur_src_nxt = sel_r;
                end
            end
            default: begin
                state_nxt = pll_clock_pkg::SRC_RUN;
            end
        endcase
        if (stop_i) begin
            base_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= pll_clock_pkg::SRC_RUN;
            cur_src_r <= 1'b0;
            xcnt_r <= 2'h0;
            vcnt_r <= 2'h0;
            base_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cur_src_r <= cur_src_nxt;
            xcnt_r <= xcnt_nxt;
            vcnt_r <= vcnt_nxt;
            base_r <= base_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign base_clk_out_o = base_r;
    assign lock_irq_o = irq_r;
    assign loop_on_o = loop_on_r;
    assign filter_track_o = track_r;
    assign feedback_div_o = fb_div_r;
    assign vco_range_o = vrs_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    property p_irq_en_hidden;
        (rd_ctl && !auto_r) |=> !rdata_o[7];
    endproperty
    a_irq_en_hidden: assert property (p_irq_en_hidden) else $error("irq enable visible in manual");

    property p_flag_irq;
        lock_toggle |=> flag_r;
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("lock toggle missed flag");

    // irq trails the flag by one cycle, so enable, mode and stop count at the flag cycle
    property p_irq_raise;
        (flag_r && irq_en_r && auto_r && !stop_i) |=> lock_irq_o;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("flag and enable gave no irq");

    property p_irq_quiet;
        (!auto_r || stop_i || !flag_r) |=> !lock_irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised without flag in auto");

    property p_flag_hidden;
        (rd_ctl && !auto_r) |=> !rdata_o[6];
    endproperty
    a_flag_hidden: assert property (p_flag_hidden) else $error("flag visible in manual");

    property p_read_clears;
        (rd_ctl && !lock_toggle) |=> !flag_r;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("control read left flag set");

    property p_loop_held;
        sel_r |=> loop_en_r;
    endproperty
    a_loop_held: assert property (p_loop_held) else $error("loop cleared under vco");

    property p_sel_guard;
        (!loop_en_r && !sel_r) |=> !sel_r;
    endproperty
    a_sel_guard: assert property (p_sel_guard) else $error("select set with loop off");

    sequence s_switch_start;
        (state_r == pll_clock_pkg::SRC_RUN) && (sel_r != cur_src_r);
    endsequence
    sequence s_switch_hold;
        (state_r == pll_clock_pkg::SRC_SWITCH) && !stop_i;
    endsequence
    property p_switch_freeze;
        s_switch_start ##1 s_switch_hold |=> $stable(base_clk_out_o);
    endproperty
    a_switch_freeze: assert property (p_switch_freeze) else $error("base clock moved in switch");

    property p_stop_clears;
        stop_i |=> !sel_r && !base_clk_out_o;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop left select set");

    property p_ones;
        rd_ctl |=> (rdata_o[3:0] == 4'hf);
    endproperty
    a_ones: assert property (p_ones) else $error("unused control bits not ones");

    property p_prog_locked;
        loop_en_r |=> $stable(mul_r) && $stable(vrs_r);
    endproperty
    a_prog_locked: assert property (p_prog_locked) else $error("programming written with loop on");

    property p_range_zero;
        vrs_zero |=> !sel_r && !loop_on_o;
    endproperty
    a_range_zero: assert property (p_range_zero) else $error("zero range left vco usable");

    property p_xld_zero;
        (rd_i && addr_i == pll_clock_pkg::ADDR_BANDWIDTH && !sel_r) |=> !rdata_o[4];
    endproperty
    a_xld_zero: assert property (p_xld_zero) else $error("crystal loss visible without vco");
endmodule

// ### tb/pll_clock_partner.sv
// model of the oscillator, vco and analog detectors around the control block
`timescale 1ns/1ps
module pll_clock_partner #(
    parameter realtime XTAL_HALF = 20.0, // crystal half period, ns
    parameter realtime VCO_HALF = 12.0 // vco half period, ns
) (
    input wire logic xtal_run_i, // crystal oscillating
    input wire logic lock_lvl_i, // lock level to present
    input wire logic track_lvl_i, // tracking level to present
    output logic crystal_clk_o, // crystal clock
    output logic vco_clk_o, // vco clock
    output logic lock_det_o, // lock detector
    output logic track_det_o // tracking detector
);
    ////////////////////////////////////////////////////////////////////////////
    // a dead crystal stops toggling, which is what loss detection must notice
    initial begin
        crystal_clk_o = 1'b0;
        forever #(XTAL_HALF) crystal_clk_o = xtal_run_i ? ~crystal_clk_o : 1'b0;
    end

    initial begin
        vco_clk_o = 1'b0;
        forever #(VCO_HALF) vco_clk_o = ~vco_clk_o;
    end

    // detector levels are async to the system clock, like the analog loop
    assign #3 lock_det_o = lock_lvl_i;
    assign #5 track_det_o = track_lvl_i;
endmodule

// ### tb/pll_clock_gen_control_tb_top.sv
// self-checking bench of the pll clock generator control block
`timescale 1ns/1ps
module pll_clock_gen_control_tb_top;
    typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] r; logic [3:0] div;} row_s;

    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic crystal_clk, vco_clk, lock_det, track_det;
    logic osc_enable_in_i = 1'b1;
    logic stop_i = 1'b0;
    logic xtal_run = 1'b1;
    logic lock_lvl = 1'b0;
    logic track_lvl = 1'b0;
    logic base_clk_out_o, lock_irq_o, loop_on_o, filter_track_o;
    logic [3:0] feedback_div_o, vco_range_o;
    logic [7:0] rv;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    row_s rows[14];

    ////////////////////////////////////////////////////////////////////////////
    always #2 clock_i = ~clock_i;

    pll_clock_gen_control u_pll_clock_gen_control (
        .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .crystal_clk_i(crystal_clk), .vco_clk_i(vco_clk), .lock_det_i(lock_det),
        .track_det_i(track_det), .osc_enable_in_i(osc_enable_in_i), .stop_i(stop_i),
        .base_clk_out_o(base_clk_out_o), .lock_irq_o(lock_irq_o), .loop_on_o(loop_on_o),
        .filter_track_o(filter_track_o), .feedback_div_o(feedback_div_o), .vco_range_o(vco_range_o)
    );

    pll_clock_partner u_pll_clock_partner (
        .xtal_run_i(xtal_run), .lock_lvl_i(lock_lvl), .track_lvl_i(track_lvl), .crystal_clk_o(crystal_clk),
        .vco_clk_o(vco_clk), .lock_det_o(lock_det), .track_det_o(track_det)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic rd_chk(input string name, input logic [1:0] a, input logic [7:0] exp);
        rd(a, rv);
        check(name, rv, exp);
    endtask

    // 240 system cycles is 960 ns of source clock; sampled once each edge has settled
    task automatic count_base(output int cnt);
        logic prev;
        cnt = 0;
        prev = base_clk_out_o;
        repeat (240) begin
            @(posedge clock_i);
            #1;
            if (base_clk_out_o && !prev) cnt++;
            prev = base_clk_out_o;
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        error_cnt++;
        end_sim();
    end

    initial begin
        rows = '{
            '{2'h0, 8'h80, 8'h0f, 4'h6}, // manual mode: enable ignored, loop off allowed
            '{2'h0, 8'h10, 8'h0f, 4'h6}, // select refused while loop off
            '{2'h2, 8'h3a, 8'h3a, 4'h3},
            '{2'h2, 8'h0a, 8'h0a, 4'h1}, // multiplier zero behaves as one
            '{2'h1, 8'h20, 8'h20, 4'h1}, // manual tracking written
            '{2'h1, 8'ha0, 8'h80, 4'h1}, // auto: tracking is live status
            '{2'h1, 8'h00, 8'h20, 4'h1}, // back to manual restores stored tracking
            '{2'h1, 8'h00, 8'h00, 4'h1}, // acquisition cleared before loop on
            '{2'h2, 8'h46, 8'h46, 4'h4},
            '{2'h0, 8'h20, 8'h2f, 4'h4}, // first write: loop on
            '{2'h2, 8'h11, 8'h46, 4'h4}, // programming frozen while loop on
            '{2'h0, 8'h30, 8'h3f, 4'h4}, // second write: select vco
            '{2'h0, 8'h10, 8'h3f, 4'h4}, // loop cannot turn off under vco
            '{2'h3, 8'hff, 8'h00, 4'h4}
        };
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_chk("control reset", 2'h0, 8'h2f);
        rd_chk("bandwidth reset", 2'h1, 8'h00);
        rd_chk("programming reset", 2'h2, 8'h66);
        check("div reset", {4'h0, feedback_div_o}, 8'h06);
        check("range reset", {4'h0, vco_range_o}, 8'h06);
        check("loop on reset", {7'h0, loop_on_o}, 8'h01);
        count_base(n);
        check("xtal base rate", {7'h0, n >= 11 && n <= 13}, 8'h01);
        // software keeps bits 3:0 of bandwidth writes at zero
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_chk("row read", rows[i].a, rows[i].r);
            check("row div", {4'h0, feedback_div_o}, {4'h0, rows[i].div});
        end
        // three crystal periods of switch time must be over before counting
        repeat (60) @(posedge clock_i);
        count_base(n);
        check("vco base rate", {7'h0, n >= 19 && n <= 21}, 8'h01);
        // crystal loss: wait n x 4 crystal periods with n = 4
        xtal_run = 1'b0;
        wr(2'h1, 8'h10);
        repeat (160) @(posedge clock_i);
        rd_chk("xtal lost", 2'h1, 8'h10);
        xtal_run = 1'b1;
        repeat (40) @(posedge clock_i);
        rd_chk("xtal back", 2'h1, 8'h00);
        @(posedge clock_i);
        stop_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        stop_i <= 1'b0;
        #1;
        check("stop base", {7'h0, base_clk_out_o}, 8'h00);
        check("stop loop", {7'h0, loop_on_o}, 8'h00);
        rd_chk("stop clears select", 2'h0, 8'h2f);
        wr(2'h1, 8'h10);
        rd_chk("xld needs vco", 2'h1, 8'h00);
        wr(2'h1, 8'h80);
        wr(2'h0, 8'ha0);
        rd_chk("irq enable auto", 2'h0, 8'haf);
        lock_lvl = 1'b1;
        track_lvl = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        check("irq raised", {7'h0, lock_irq_o}, 8'h01);
        check("filter track auto", {7'h0, filter_track_o}, 8'h01);
        rd_chk("lock auto", 2'h1, 8'he0);
        rd_chk("flag set", 2'h0, 8'hef);
        repeat (2) @(posedge clock_i);
        #1;
        check("irq cleared", {7'h0, lock_irq_o}, 8'h00);
        rd_chk("flag cleared", 2'h0, 8'haf);
        wr(2'h1, 8'h00);
        rd_chk("manual hides", 2'h0, 8'h2f);
        rd_chk("lock manual", 2'h1, 8'h00);
        check("filter acq", {7'h0, filter_track_o}, 8'h00);
        wr(2'h0, 8'h00);
        wr(2'h2, 8'h40);
        wr(2'h0, 8'h20);
        wr(2'h0, 8'h30);
        rd_chk("zero range", 2'h0, 8'h2f);
        check("zero range loop", {7'h0, loop_on_o}, 8'h00);
        // reset in mid-run, with auto mode on and the range field cleared
        wr(2'h1, 8'h80);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_chk("control again", 2'h0, 8'h2f);
        rd_chk("bandwidth again", 2'h1, 8'h00);
        rd_chk("programming again", 2'h2, 8'h66);
        end_sim();
    end
endmodule
